// ---- include/lpc_pkg.sv ----
/*
  package of the lin phy control and wake-up block: register offsets, field positions,
  reset values, slew-rate codes and timing counts.
  assumes a 10 mhz clock and an apb register bus with 32-bit data.
*/
package lpc_pkg;

  localparam logic [7:0] LPC_OFF_CONFIG  = 8'h00;
  localparam logic [7:0] LPC_OFF_TEST    = 8'h04;
  localparam logic [7:0] LPC_OFF_CONTROL = 8'h08;
  localparam logic [7:0] LPC_OFF_STATUS  = 8'h0C;

  localparam int LPC_CFG_TODIS_BIT = 7;
  localparam int LPC_CFG_SLR_LSB   = 0;
  localparam int LPC_CTL_PE_BIT    = 0;
  localparam int LPC_CTL_WUE_BIT   = 1;
  localparam int LPC_CTL_PUE_BIT   = 2;
  localparam int LPC_CTL_RXO_BIT   = 3;

  localparam logic [7:0] LPC_CONFIG_RST  = 8'h00;
  localparam logic [7:0] LPC_TEST_RST    = 8'h00;
  localparam logic [3:0] LPC_CONTROL_RST = 4'h0;

  typedef enum logic [1:0] {
    LPC_SLR_NORMAL = 2'b00,
    LPC_SLR_SLOW   = 2'b01,
    LPC_SLR_FAST   = 2'b10,
    LPC_SLR_RSVD   = 2'b11
  } lpc_slew_t;

  typedef enum logic [1:0] {
    LPC_WU_IDLE = 2'b00,
    LPC_WU_DOM  = 2'b01,
    LPC_WU_ARM  = 2'b10
  } lpc_wu_state_t;

  localparam int LPC_CLK_HZ         = 10_000_000;
  localparam int LPC_WUFR_TIME_NS   = 100_000;
  localparam int LPC_WUFR_CYCLES    = (LPC_WUFR_TIME_NS * (LPC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LPC_CNT_W          = 12;

endpackage

// ---- logic/lpc_apb_slave.sv ----
/*
  apb slave front end: turns a transfer into write and read strobes that stay high for the whole access phase.
  assumes a single clock; pready comes from the top, registered, in the second access cycle.
*/
`timescale 1ns/1ps
module lpc_apb_slave (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  output logic             wr_stb_o,
  output logic             rd_stb_o
);
  import lpc_pkg::*;

  logic access;

  always_comb begin
    access   = psel_i & penable_i & en_i;
    wr_stb_o = access & pwrite_i;
    rd_stb_o = access & ~pwrite_i;
  end
endmodule

// ---- logic/lpc_wakeup_filter.sv ----
/*
  wake-up filter: times a dominant bus level and fires one pulse on the rising edge
  that ends a dominant period longer than the filter time.
  assumes bus_dominant_i is synchronous to clk_i.
*/
`timescale 1ns/1ps
module lpc_wakeup_filter (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        armed_i,
  input  wire logic        bus_dominant_i,
  output logic             pulse_o
);
  import lpc_pkg::*;

  lpc_wu_state_t         state;
  lpc_wu_state_t         next_state;
  logic [LPC_CNT_W-1:0]  cnt;
  logic [LPC_CNT_W-1:0]  next_cnt;
  logic                  next_pulse;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_pulse = 1'b0;
    if (!armed_i) begin
      next_state = LPC_WU_IDLE;
      next_cnt   = '0;
    end else begin
      case (state)
        LPC_WU_IDLE: begin
          next_cnt = '0;
          if (bus_dominant_i) begin
            next_state = LPC_WU_DOM;
            next_cnt   = LPC_CNT_W'(1);
          end
        end
        LPC_WU_DOM: begin
          if (!bus_dominant_i) begin
            next_state = LPC_WU_IDLE;
          end else if (cnt >= LPC_CNT_W'(LPC_WUFR_CYCLES)) begin
            // dominant strictly longer than the filter time
            next_state = LPC_WU_ARM;
          end else begin
            next_cnt = cnt + LPC_CNT_W'(1);
          end
        end
        LPC_WU_ARM: begin
          if (!bus_dominant_i) begin
            next_pulse = 1'b1;
            next_state = LPC_WU_IDLE;
          end
        end
        default: begin
          next_state = LPC_WU_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= LPC_WU_IDLE;
      cnt     <= '0;
      pulse_o <= 1'b0;
    end else if (en_i) begin
      state   <= next_state;
      cnt     <= next_cnt;
      pulse_o <= next_pulse;
    end
  end

  wake_one_shot_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && pulse_o |=> !pulse_o)
    else $error("wake-up pulse longer than one cycle");
endmodule

// ---- logic/lpc_top.sv ----
/*
  lin phy digital control: apb registers, slew-rate and timeout settings locked outside
  shutdown, factory test register, stop-mode wake-up and receive path routing.
  assumes apb master on clk_i, the analog phy and the serial interface on the other ports.
*/
`timescale 1ns/1ps
module lpc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        special_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic        bus_dominant_i,
  output logic             timeout_enable_o,
  output logic [1:0]       slew_mode_o,
  output logic             slew_reserved_o,
  output logic             standby_active_o,
  output logic             pullup_330k_o,
  output logic             receive_only_o,
  output logic             phy_receive_out_o,
  output logic             wakeup_pulse_o,
  output logic [7:0]       test_bits_o
);
  import lpc_pkg::*;

  logic       wr_stb;
  logic       rd_stb;
  logic       wu_pulse;
  logic [7:0] config_reg;
  logic [7:0] test_reg;
  logic [3:0] control_reg;
  logic       stop_q;
  logic       wake_seen;
  logic [7:0] next_config;
  logic [7:0] next_test;
  logic [3:0] next_control;
  logic       next_wake_seen;
  logic [31:0] next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  logic       next_timeout_en;
  logic [1:0] next_slew;
  logic       next_slew_rsvd;
  logic       next_standby;
  logic       next_pullup;
  logic       next_receive_only_select;
  logic       next_rx_out;
  logic       phy_en;
  logic       wu_en;
  logic       mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == LPC_OFF_CONFIG) || (a == LPC_OFF_TEST) ||
                (a == LPC_OFF_CONTROL) || (a == LPC_OFF_STATUS);
  endfunction

  lpc_apb_slave u_apb (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (en_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .wr_stb_o  (wr_stb),
    .rd_stb_o  (rd_stb)
  );

  lpc_wakeup_filter u_wake (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .en_i           (en_i),
    .armed_i        (stop_mode_i & wu_en),
    .bus_dominant_i (bus_dominant_i),
    .pulse_o        (wu_pulse)
  );

  // register file
  always_comb begin
    phy_en       = control_reg[LPC_CTL_PE_BIT];
    wu_en        = control_reg[LPC_CTL_WUE_BIT];
    mapped       = is_mapped(paddr_i);
    next_config  = config_reg;
    next_test    = test_reg;
    next_control = control_reg;
    if (wr_stb && !pready_o) begin
      case (paddr_i)
        LPC_OFF_CONFIG: begin
          // locked fields keep their value while the phy runs
          if (!phy_en) begin
            next_config[LPC_CFG_TODIS_BIT] = pwdata_i[LPC_CFG_TODIS_BIT];
            next_config[LPC_CFG_SLR_LSB+:2] = pwdata_i[LPC_CFG_SLR_LSB+:2];
          end
        end
        LPC_OFF_TEST: begin
          if (special_mode_i) begin
            next_test = pwdata_i[7:0];
          end
        end
        LPC_OFF_CONTROL: begin
          next_control = pwdata_i[3:0];
        end
        default: begin
          next_control = control_reg;
        end
      endcase
    end
  end

  // apb answer: one access cycle, then pready drops so each transfer completes once
  always_comb begin
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata_o;
    if ((wr_stb || rd_stb) && !pready_o) begin
      next_pready  = 1'b1;
      next_pslverr = ~mapped;
      next_prdata  = 32'h0000_0000;
      if (rd_stb) begin
        case (paddr_i)
          LPC_OFF_CONFIG:  next_prdata = {24'h00_0000, config_reg};
          LPC_OFF_TEST:    next_prdata = {24'h00_0000, test_reg};
          LPC_OFF_CONTROL: next_prdata = {28'h000_0000, control_reg};
          LPC_OFF_STATUS:  next_prdata = {30'h0000_0000, wake_seen, stop_q};
          default:         next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // phy control outputs and wake status
  always_comb begin
    next_timeout_en = ~config_reg[LPC_CFG_TODIS_BIT];
    next_slew       = config_reg[LPC_CFG_SLR_LSB+:2];
    next_slew_rsvd  = (config_reg[LPC_CFG_SLR_LSB+:2] == LPC_SLR_RSVD);
    // without wake-up, standby is electrically shutdown
    next_standby    = stop_mode_i & wu_en;
    next_pullup     = ~wu_en | ~control_reg[LPC_CTL_PUE_BIT];
    next_receive_only_select     = control_reg[LPC_CTL_RXO_BIT];
    // receive path is handed back on stop exit, dominant bus included
    next_rx_out     = stop_mode_i ? 1'b0 : (phy_en & bus_dominant_i);
    next_wake_seen  = wake_seen;
    if (rd_stb && !pready_o && paddr_i == LPC_OFF_STATUS) begin
      next_wake_seen = 1'b0;
    end
    if (wu_pulse) begin
      next_wake_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_reg        <= LPC_CONFIG_RST;
      test_reg          <= LPC_TEST_RST;
      control_reg       <= LPC_CONTROL_RST;
      stop_q            <= 1'b0;
      wake_seen         <= 1'b0;
      prdata_o          <= 32'h0000_0000;
      pready_o          <= 1'b0;
      pslverr_o         <= 1'b0;
      timeout_enable_o  <= 1'b1;
      slew_mode_o       <= 2'b00;
      slew_reserved_o   <= 1'b0;
      standby_active_o  <= 1'b0;
      pullup_330k_o     <= 1'b1;
      receive_only_o    <= 1'b0;
      phy_receive_out_o <= 1'b0;
      wakeup_pulse_o    <= 1'b0;
      test_bits_o       <= 8'h00;
    end else if (en_i) begin
      config_reg        <= next_config;
      test_reg          <= next_test;
      control_reg       <= next_control;
      stop_q            <= stop_mode_i;
      wake_seen         <= next_wake_seen;
      prdata_o          <= next_prdata;
      pready_o          <= next_pready;
      pslverr_o         <= next_pslverr;
      timeout_enable_o  <= next_timeout_en;
      slew_mode_o       <= next_slew;
      slew_reserved_o   <= next_slew_rsvd;
      standby_active_o  <= next_standby;
      pullup_330k_o     <= next_pullup;
      receive_only_o    <= next_receive_only_select;
      phy_receive_out_o <= next_rx_out;
      wakeup_pulse_o    <= wu_pulse;
      test_bits_o       <= test_reg;
    end
  end

  sequence write_locked_s;
    en_i && wr_stb && !pready_o && paddr_i == LPC_OFF_CONFIG && phy_en;
  endsequence

  locked_cfg_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    write_locked_s |=> $stable(config_reg))
    else $error("locked config field changed while phy enabled");
  slew_shutdown_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(config_reg[1:0]) |-> $past(!control_reg[LPC_CTL_PE_BIT]))
    else $error("slew field changed outside shutdown");
  todis_shutdown_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(config_reg[7]) |-> $past(!control_reg[LPC_CTL_PE_BIT]))
    else $error("timeout disable changed outside shutdown");
  timeout_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && $past(en_i) |-> timeout_enable_o == !$past(config_reg[7]))
    else $error("timeout enable does not follow disable bit");
  test_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wr_stb && !pready_o && paddr_i == LPC_OFF_TEST && !special_mode_i |=> $stable(test_reg))
    else $error("test register written outside special mode");
  pullup_force_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !wu_en |=> pullup_330k_o)
    else $error("pullup not 330k with wake-up disabled");
  no_wake_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !wu_en ##1 en_i && !wu_en |=> !wakeup_pulse_o && !standby_active_o)
    else $error("wake-up activity with wake-up disabled");
  pullup_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wu_en && !control_reg[LPC_CTL_PUE_BIT] |=> pullup_330k_o)
    else $error("pullup_select 0 did not give 330k");
  receive_only_select_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i |=> receive_only_o == $past(control_reg[LPC_CTL_RXO_BIT]))
    else $error("receive-only mode not taken from control");

  // apb handshake: every access gets exactly one answer cycle
  sequence apb_access_s;
    en_i && psel_i && penable_i && !pready_o;
  endsequence

  sequence apb_commit_s;
    en_i && psel_i && penable_i && pready_o;
  endsequence

  apb_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    apb_access_s |=> pready_o)
    else $error("apb access got no answer");

  pready_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    apb_commit_s |=> !pready_o)
    else $error("pready stood longer than one cycle");

  bad_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && psel_i && penable_i && !pready_o && !mapped |=> pslverr_o)
    else $error("unmapped access without error response");

  // a read of the test register must work in every chip mode
  sequence test_read_s;
    en_i && psel_i && penable_i && !pwrite_i && !pready_o && paddr_i == LPC_OFF_TEST;
  endsequence

  test_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    test_read_s |=> prdata_o == {24'h00_0000, $past(test_reg)})
    else $error("test register not readable");

  slew_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i |=> slew_mode_o == $past(config_reg[LPC_CFG_SLR_LSB+:2]) &&
             slew_reserved_o == ($past(config_reg[LPC_CFG_SLR_LSB+:2]) == LPC_SLR_RSVD))
    else $error("slew code or reserved flag wrong");

  standby_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i |=> standby_active_o == $past(stop_mode_i && wu_en))
    else $error("standby does not follow stop and wake-up enable");

  // wake path: nothing may reach the serial side unless armed two cycles earlier
  sequence wake_blocked_s;
    en_i && !(stop_mode_i && wu_en) ##1 en_i;
  endsequence

  wake_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wake_blocked_s |=> !wakeup_pulse_o)
    else $error("wake-up pulse while not armed");

  wake_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i |=> wakeup_pulse_o == $past(wu_pulse))
    else $error("filter pulse not passed to serial side");

  // set wins over a status read in the same cycle, so no wake-up is lost
  wake_status_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wu_pulse |=> wake_seen)
    else $error("wake status not set by pulse");

  // receive path is silent in stop and follows the bus again once stop ends while phy_en is set
  rx_route_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !stop_mode_i && phy_en && bus_dominant_i |=> phy_receive_out_o)
    else $error("dominant bus not routed to serial receive");

  rx_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && stop_mode_i |=> !phy_receive_out_o)
    else $error("receive path active in stop");
endmodule

// ---- tb/lpc_bus_model.sv ----
/*
  far-side model: the lin bus as seen through the receiver, plus the serial side
  counting wake-up pulses. assumes go_i is a one-cycle pulse with len_i stable.
*/
`timescale 1ns/1ps
module lpc_bus_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  input  wire logic [15:0] len_i,
  input  wire logic        pulse_i,
  output logic             dom_o,
  output logic [7:0]       pulses_o
);
  logic [15:0] left;

  // a dominant period of len_i cycles, then recessive again
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= 16'h0000;
      dom_o <= 1'b0;
      pulses_o <= 8'h00;
    end else begin
      if (go_i) begin
        left <= len_i;
      end else if (left != 16'h0000) begin
        left <= left - 16'h0001;
      end
      dom_o <= go_i || (left > 16'h0001);
      if (pulse_i) begin
        pulses_o <= pulses_o + 8'h01;
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
/*
  self-checking bench of the lin phy control block over apb.
  assumes the bus model drives bus_dominant_i and counts wake pulses.
*/
`timescale 1ns/1ps
module testbench;
  import lpc_pkg::*;
  logic        clk_i, rst_n_i, en_i, psel, penable, pwrite, special, stop, go, er;
  logic [7:0]  paddr, test_bits, pulses;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] len;
  logic [1:0]  slew;
  logic        ready, slverr, to_en, slew_rsv, stby, pu330, rxo, rxd, wpulse, dom;
  int          err_count, checked;

  lpc_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(ready),
    .pslverr_o(slverr), .special_mode_i(special), .stop_mode_i(stop), .bus_dominant_i(dom),
    .timeout_enable_o(to_en), .slew_mode_o(slew), .slew_reserved_o(slew_rsv),
    .standby_active_o(stby), .pullup_330k_o(pu330), .receive_only_o(rxo),
    .phy_receive_out_o(rxd), .wakeup_pulse_o(wpulse), .test_bits_o(test_bits));
  lpc_bus_model i_bus (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .len_i(len),
    .pulse_i(wpulse), .dom_o(dom), .pulses_o(pulses));

  always #50 clk_i = ~clk_i;

  task automatic stop_test();
    $display("errors %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(0, 1, "apb hang");
      stop_test();
    end
    rd = prdata;
    er = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic run_dom(input logic [15:0] n, input logic [7:0] exp, input string msg);
    logic [7:0] p0;
    p0 = pulses;
    @(posedge clk_i);
    go <= 1'b1;
    len <= n;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (n + 16'h0014) @(posedge clk_i);
    @(negedge clk_i);
    chk(pulses - p0, exp, msg);
  endtask

  task automatic t_slew();
    for (int i = 0; i < 4; i++) begin
      apb(1, LPC_OFF_CONFIG, {24'h0, i[0], 5'h0, i[1:0]});
      chk(slew, i[1:0], "slew code");
      chk(slew_rsv, i == 3, "reserved flag");
      chk(to_en, !i[0], "timeout enable");
    end
    apb(1, LPC_OFF_CONTROL, 32'h0000_0001);
    apb(1, LPC_OFF_CONFIG, 32'h0000_0001);
    chk(slew, 2'b11, "slew locked");
    chk(to_en, 1'b0, "disable locked");
    apb(0, LPC_OFF_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0083, "config readback");
    apb(1, LPC_OFF_CONTROL, 32'h0000_0000);
  endtask

  task automatic t_test();
    apb(1, LPC_OFF_TEST, 32'h0000_00A5);
    apb(0, LPC_OFF_TEST, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "test write outside special");
    special <= 1'b1;
    apb(1, LPC_OFF_TEST, 32'h0000_00A5);
    apb(0, LPC_OFF_TEST, 32'h0000_0000);
    chk(rd, 32'h0000_00A5, "test write in special");
    chk(test_bits, 8'hA5, "test bits");
    special <= 1'b0;
    apb(0, 8'h10, 32'h0000_0000);
    chk(er, 1'b1, "unmapped error");
  endtask

  task automatic t_pullup();
    for (int i = 0; i < 4; i++) begin
      apb(1, LPC_OFF_CONTROL, {28'h0, 1'b0, i[0], i[1], 1'b0});
      chk(pu330, i != 3, "pullup choice");
    end
    // clock enable low must hold every output where it stands
    @(posedge clk_i);
    en_i <= 1'b0;
    stop <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk(stby, 1'b0, "frozen standby");
    @(posedge clk_i);
    en_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(stby, 1'b1, "standby after enable");
    @(posedge clk_i);
    stop <= 1'b0;
  endtask

  task automatic t_wake();
    apb(1, LPC_OFF_CONTROL, 32'h0000_0002);
    stop <= 1'b1;
    @(negedge clk_i);
    @(negedge clk_i);
    chk(stby, 1'b1, "standby wake capable");
    run_dom(16'd1010, 8'h01, "wake pulse");
    apb(0, LPC_OFF_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0003, "wake status set");
    apb(0, LPC_OFF_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "wake status read clear");
    run_dom(16'd900, 8'h00, "short dominant");
    apb(1, LPC_OFF_CONTROL, 32'h0000_0000);
    chk(stby, 1'b0, "standby as shutdown");
    run_dom(16'd1010, 8'h00, "wake disabled");
    stop <= 1'b0;
  endtask

  task automatic t_exit();
    for (int i = 0; i < 2; i++) begin
      apb(1, LPC_OFF_CONTROL, {28'h0, i[0], 3'b001});
      stop <= 1'b1;
      @(posedge clk_i);
      go <= 1'b1;
      len <= 16'd60;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk(rxd, 1'b0, "receive quiet in stop");
      stop <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk(rxo, i[0], "mode after stop");
      chk(rxd, 1'b1, "receive rerouted");
      repeat (60) @(posedge clk_i);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    chk(0, 1, "run hang");
    stop_test();
  end

  initial begin
    {clk_i, rst_n_i, psel, penable, pwrite, special, stop, go} = 8'h00;
    en_i = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    len = 16'h0000;
    err_count = 0;
    checked = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk(to_en, 1'b1, "timeout on at reset");
    chk(pu330, 1'b1, "pullup at reset");
    t_slew();
    t_test();
    t_pullup();
    t_wake();
    t_exit();
    stop_test();
  end
endmodule
